// *** shared/port_info_pkg.sv ***
package port_info_pkg;

	// ----------------------------------------
	// Register map (byte addresses, port 1)
	// ----------------------------------------
	localparam logic [11:0] PMSC_OFFSET = 12'h404;
	localparam logic [11:0] LINK_INFO_OFFSET = 12'h408;
	localparam logic [11:0] PORT_STRIDE = 12'h010;
	localparam logic [11:0] PORT_CTRL_OFFSET = 12'h40c;
	localparam logic [31:0] LINK_INFO_RESET = 32'h0000_0000;
	localparam logic [31:0] PMSC_RESET = 32'h0000_0000;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int TEST_CTRL_LSB = 28;
	localparam int TEST_CTRL_MSB = 31;
	localparam int SLEEP_SLOT_LSB = 8;
	localparam int SLEEP_SLOT_MSB = 15;
	localparam int ERR_CNT_LSB = 0;
	localparam int ERR_CNT_MSB = 15;
	localparam int RX_LANE_LSB = 16;
	localparam int RX_LANE_MSB = 19;
	localparam int TX_LANE_LSB = 20;
	localparam int TX_LANE_MSB = 23;
	localparam int ERR_CNT_W = 16;
	localparam int LANE_W = 4;

	// Control register of my own: bit 0 selects USB2 protocol port
	localparam int CTRL_USB2_BIT = 0;

	// ----------------------------------------
	// Test-control encodings
	// ----------------------------------------
	localparam logic [3:0] TEST_OFF = 4'h0;
	localparam logic [3:0] TEST_J_STATE = 4'h1;
	localparam logic [3:0] TEST_K_STATE = 4'h2;
	localparam logic [3:0] TEST_SE0_NAK = 4'h3;
	localparam logic [3:0] TEST_PACKET = 4'h4;
	localparam logic [3:0] TEST_FORCE_EN = 4'h5;
	localparam logic [3:0] TEST_ERROR = 4'hf;

	// Port link state codes as seen on the link side
	localparam logic [3:0] PLS_U0 = 4'h0;
	localparam logic [3:0] PLS_U2 = 4'h2;
	localparam logic [3:0] PLS_DISABLED = 4'h4;
	localparam logic [3:0] PLS_RECOVERY = 4'h8;

	typedef enum logic [1:0] {
		LINE_L0,
		LINE_L1,
		LINE_OTHER
	} line_state_t;

endpackage

// *** rtl/link_error_counter.sv ***
module link_error_counter
	import port_info_pkg::*;
#(
	parameter int WIDTH = port_info_pkg::ERR_CNT_W
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic clear,
	input wire logic bump,
	output logic [WIDTH-1:0] count
);
	logic [WIDTH-1:0] count_ff;
	logic [WIDTH-1:0] nxt_count;
	wire at_max = &count_ff;

	// --------------------------------
	// Saturating count; an event in a clear cycle still counts
	// --------------------------------
	assign nxt_count = clear ? {{(WIDTH-1){1'b0}}, bump} :
		(bump && !at_max) ? count_ff + {{(WIDTH-1){1'b0}}, 1'b1} : count_ff;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			count_ff <= '0;
		end else begin
			count_ff <= nxt_count;
		end
	end

	assign count = count_ff;
endmodule

// *** rtl/usb_port_test_and_link_info.sv ***
// Behaviour
// - Four-bit test-control field in bits 31:28
// - USB2 test encodings; 15 marks error
// - Nonzero test only when disabled, else 15
// - Line L0 is U0, L1 is U2
// - Sleep slot gives LPM target address
// - Link info register, 32 bits, zero reset
// - Error counter clears on resets, zero writes
// - Count U0-to-Recovery entries, saturating
// - Bits 19:16 zero-based receive lanes
// - Bits 23:20 zero-based transmit lanes
// - USB2 port: link info is reserved
//
// Our own choice: register access over AHB-Lite.
module usb_port_test_and_link_info
	import port_info_pkg::*;
#(
	parameter int PORT_NUM = 1
) (
	// ----------------------------------------
	// Clock, reset and register bus
	// ----------------------------------------
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// ----------------------------------------
	// Controller and port status inputs
	// ----------------------------------------
	input wire logic controller_reset_command,
	input wire logic port_reset_flag,
	input wire logic connect_status_flag,
	input wire logic [3:0] port_link_state,
	input wire logic [1:0] usb2_line_state,
	// ----------------------------------------
	// Link negotiation inputs
	// ----------------------------------------
	input wire logic simplex_sublink,
	input wire logic [3:0] receive_lane_count,
	input wire logic [3:0] transmit_lane_count,
	// ----------------------------------------
	// Test mode and link power outputs
	// ----------------------------------------
	output logic [3:0] test_mode,
	output logic test_active,
	output logic [7:0] sleep_target_slot,
	output logic lpm_target_valid,
	output logic [3:0] effective_link_state
);
	import port_info_pkg::*;

	// ----------------------------------------
	// Address map for this port
	// ----------------------------------------
	localparam logic [11:0] PORT_BASE = 12'(PORT_STRIDE * 12'(PORT_NUM - 1));
	localparam logic [11:0] PMSC_ADDR = PMSC_OFFSET + PORT_BASE;
	localparam logic [11:0] LI_ADDR = LINK_INFO_OFFSET + PORT_BASE;
	localparam logic [11:0] CTRL_ADDR = PORT_CTRL_OFFSET + PORT_BASE;

	// ----------------------------------------
	// AHB-Lite address phase capture
	// ----------------------------------------
	logic wr_pend_ff;
	logic [11:0] addr_ff;
	logic [11:0] nxt_addr;
	logic nxt_wr_pend;
	wire ahb_take = hsel && hready && htrans[1];
	// Reads decode the live address phase; writes use the captured one
	always_comb begin
		nxt_addr = addr_ff;
		nxt_wr_pend = 1'b0;
		if (ahb_take) begin
			nxt_addr = haddr[11:0];
			nxt_wr_pend = hwrite;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_ff <= 1'b0;
			addr_ff <= 12'h000;
		end else begin
			wr_pend_ff <= nxt_wr_pend;
			addr_ff <= nxt_addr;
		end
	end

	// Slave never stalls and never errors
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	wire wr_pmsc = wr_pend_ff && (addr_ff == PMSC_ADDR);
	wire wr_li = wr_pend_ff && (addr_ff == LI_ADDR);
	wire wr_ctrl = wr_pend_ff && (addr_ff == CTRL_ADDR);
	wire rd_pmsc = haddr[11:0] == PMSC_ADDR;
	wire rd_li = haddr[11:0] == LI_ADDR;
	wire rd_ctrl = haddr[11:0] == CTRL_ADDR;
	wire rd_take = ahb_take && !hwrite;

	// ----------------------------------------
	// Port control (protocol select)
	// ----------------------------------------
	logic usb2_port_ff;
	logic nxt_usb2_port;
	always_comb begin
		nxt_usb2_port = usb2_port_ff;
		if (controller_reset_command) begin
			nxt_usb2_port = 1'b0;
		end else if (wr_ctrl) begin
			nxt_usb2_port = hwdata[CTRL_USB2_BIT];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			usb2_port_ff <= 1'b0;
		end else begin
			usb2_port_ff <= nxt_usb2_port;
		end
	end

	// ----------------------------------------
	// Link state mapping
	// ----------------------------------------
	line_state_t line_st;
	always_comb begin
		case (usb2_line_state)
			2'd0: line_st = LINE_L0;
			2'd1: line_st = LINE_L1;
			default: line_st = LINE_OTHER;
		endcase
	end

	logic [3:0] mapped_state;
	always_comb begin
		mapped_state = port_link_state;
		if (usb2_port_ff) begin
			case (line_st)
				LINE_L0: mapped_state = PLS_U0;
				LINE_L1: mapped_state = PLS_U2;
				LINE_OTHER: mapped_state = port_link_state;
				default: mapped_state = port_link_state;
			endcase
		end
	end
	assign effective_link_state = mapped_state;

	// ----------------------------------------
	// Power-management fields: test control, sleep slot
	// ----------------------------------------
	logic [3:0] test_ff;
	logic [3:0] nxt_test;
	logic [7:0] slot_ff;
	logic [7:0] nxt_slot;
	wire [3:0] test_wr = hwdata[TEST_CTRL_MSB:TEST_CTRL_LSB];
	wire port_disabled = (mapped_state == PLS_DISABLED);

	// Nonzero request outside Disabled reports the error code
	always_comb begin
		nxt_test = test_ff;
		if (controller_reset_command) begin
			nxt_test = TEST_OFF;
		end else if (wr_pmsc) begin
			if (test_wr == TEST_OFF) begin
				nxt_test = TEST_OFF;
			end else if (port_disabled) begin
				nxt_test = test_wr;
			end else begin
				nxt_test = TEST_ERROR;
			end
		end
	end

	always_comb begin
		nxt_slot = slot_ff;
		if (controller_reset_command) begin
			nxt_slot = 8'h00;
		end else if (wr_pmsc) begin
			nxt_slot = hwdata[SLEEP_SLOT_MSB:SLEEP_SLOT_LSB];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			test_ff <= TEST_OFF;
			slot_ff <= 8'h00;
		end else begin
			test_ff <= nxt_test;
			slot_ff <= nxt_slot;
		end
	end

	// Only documented modes drive the port; reserved and error stay idle
	assign test_active = usb2_port_ff && (test_ff >= TEST_J_STATE)
		&& (test_ff <= TEST_FORCE_EN);
	assign test_mode = test_ff;
	assign sleep_target_slot = slot_ff;
	assign lpm_target_valid = usb2_port_ff && (slot_ff != 8'h00);

	// ----------------------------------------
	// Link error counter
	// ----------------------------------------
	logic pr_ff;
	logic [3:0] pls_ff;
	logic [ERR_CNT_W-1:0] err_cnt;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pr_ff <= 1'b0;
			pls_ff <= PLS_U0;
		end else begin
			pr_ff <= port_reset_flag;
			pls_ff <= port_link_state;
		end
	end

	wire pr_fall = pr_ff && !port_reset_flag;
	wire sw_zero = wr_li && (hwdata[ERR_CNT_MSB:ERR_CNT_LSB] == 16'h0000);
	wire cnt_clear = controller_reset_command || pr_fall || sw_zero;
	wire recov_entry = !usb2_port_ff && (pls_ff == PLS_U0)
		&& (port_link_state == PLS_RECOVERY);

	link_error_counter #(
		.WIDTH(ERR_CNT_W)
	) u_err_cnt (
		.hclk(hclk),
		.hresetn(hresetn),
		.clear(cnt_clear),
		.bump(recov_entry),
		.count(err_cnt)
	);

	// ----------------------------------------
	// Lane counts
	// ----------------------------------------
	wire lanes_zero = simplex_sublink || !connect_status_flag || usb2_port_ff;
	logic [LANE_W-1:0] lane_in [2];
	logic [LANE_W-1:0] lane_out [2];
	assign lane_in[0] = receive_lane_count;
	assign lane_in[1] = transmit_lane_count;
	for (genvar i = 0; i < 2; i++) begin : g_lane
		assign lane_out[i] = lanes_zero ? '0 : lane_in[i];
	end
	wire [LANE_W-1:0] rx_lanes = lane_out[0];
	wire [LANE_W-1:0] tx_lanes = lane_out[1];

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	wire [31:0] li_word = usb2_port_ff ? LINK_INFO_RESET :
		{8'h00, tx_lanes, rx_lanes, err_cnt};
	wire [31:0] pmsc_word = {test_ff, 12'h000, slot_ff, 8'h00};
	wire [31:0] ctrl_word = {31'h0000_0000, usb2_port_ff};
	// Unmapped offsets read as zero
	logic [31:0] rd_word;
	always_comb begin
		rd_word = 32'h0000_0000;
		if (rd_li) begin
			rd_word = li_word;
		end else if (rd_pmsc) begin
			rd_word = pmsc_word;
		end else if (rd_ctrl) begin
			rd_word = ctrl_word;
		end
	end

	logic [31:0] rdata_ff;
	logic [31:0] nxt_rdata;
	assign nxt_rdata = rd_take ? rd_word : rdata_ff;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rdata_ff <= PMSC_RESET;
		end else begin
			rdata_ff <= nxt_rdata;
		end
	end

	assign hrdata = rdata_ff;
endmodule

// *** verif/port_info_asserts.sv ***
module port_info_asserts
	import port_info_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic controller_reset_command,
	input wire logic connect_status_flag,
	input wire logic simplex_sublink,
	input wire logic [3:0] port_link_state,
	input wire logic [1:0] usb2_line_state,
	input wire logic [3:0] test_mode,
	input wire logic test_active,
	input wire logic [7:0] sleep_target_slot,
	input wire logic lpm_target_valid,
	input wire logic [3:0] effective_link_state
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	wire take = hsel && hready && htrans[1];
	wire pm_wr = take && hwrite && haddr[11:0] == PMSC_OFFSET;
	wire li_rd = take && !hwrite && haddr[11:0] == LINK_INFO_OFFSET;
	wire [3:0] wr_mode = hwdata[31:28];
	wire off = effective_link_state == PLS_DISABLED;
	chk_bus_okay: assert property (hreadyout && !hresp)
		else $error("bus response not okay");
	chk_test_error: assert property (pm_wr ##1 (wr_mode != 0 && !off
		&& !controller_reset_command) |=> test_mode == TEST_ERROR)
		else $error("test error code missing");
	chk_test_store: assert property (pm_wr ##1 (off && !controller_reset_command)
		|=> test_mode == $past(wr_mode))
		else $error("test mode not stored");
	chk_active_mode: assert property (test_active |-> test_mode >= 1 && test_mode <= 5)
		else $error("test active on bad mode");
	chk_line_map: assert property (usb2_line_state == 0 && effective_link_state == PLS_U0
		|| usb2_line_state == 1 && effective_link_state == PLS_U2
		|| effective_link_state == port_link_state)
		else $error("line state mapping wrong");
	chk_lpm_slot: assert property (lpm_target_valid |-> sleep_target_slot != 0)
		else $error("lpm target without slot");
	chk_info_top: assert property (li_rd |=> hrdata[31:24] == 0)
		else $error("link info top byte set");
	chk_lane_gate: assert property (li_rd && (!connect_status_flag || simplex_sublink)
		|=> hrdata[23:16] == 0)
		else $error("lane counts not gated");
	chk_ctrl_reset: assert property (controller_reset_command
		|=> test_mode == 0 && sleep_target_slot == 0)
		else $error("controller reset left state");
endmodule
bind usb_port_test_and_link_info port_info_asserts u_chk (.*);

// *** verif/link_partner.sv ***
module link_partner
	import port_info_pkg::*;
#(
	parameter logic [3:0] RX_LANES = 4'h3,
	parameter logic [3:0] TX_LANES = 4'h5
) (
	input wire logic hclk,
	input wire logic go_off,
	input wire logic glitch,
	input wire logic link_up,
	output logic [3:0] port_link_state,
	output logic connect_status_flag,
	output logic [3:0] receive_lane_count,
	output logic [3:0] transmit_lane_count
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] idle_pat = 4'ha;
	initial port_link_state = PLS_U0;
	// Error recovery is a one-cycle trip through Recovery
	always @(posedge hclk) begin
		idle_pat <= ~idle_pat;
		port_link_state <= go_off ? PLS_DISABLED : glitch ? PLS_RECOVERY : PLS_U0;
	end
	assign connect_status_flag = link_up;
	// Unconnected lanes toggle so stale counts cannot pass
	assign receive_lane_count = link_up ? RX_LANES : idle_pat;
	assign transmit_lane_count = link_up ? TX_LANES : ~idle_pat;
endmodule

// *** verif/testbench.sv ***
module testbench
	import port_info_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, go_off = 0, glitch = 0, link_up = 0;
	logic controller_reset_command = 0, port_reset_flag = 0, simplex_sublink = 0;
	logic [31:0] haddr = 0, hwdata = 0, v;
	logic [1:0] htrans = 0, usb2_line_state = 2;
	logic [2:0] hsize = 3'h2;
	wire [31:0] hrdata;
	wire hreadyout, hresp, test_active, lpm_target_valid, connect_status_flag;
	wire [3:0] test_mode, effective_link_state, port_link_state;
	wire [3:0] receive_lane_count, transmit_lane_count;
	wire [7:0] sleep_target_slot;
	wire hready = hreadyout;
	int failures = 0, checks_done = 0;
	usb_port_test_and_link_info u_dut (.*);
	link_partner u_link (.*);
	initial forever #25 hclk = ~hclk;
	task report_and_stop;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask
	task step;
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hready !== 1'b1 && n < 64);
		if (hready !== 1'b1) begin
			failures++;
			report_and_stop;
		end
	endtask
	task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		hsel <= 1;
		hwrite <= w;
		haddr <= {20'h0, a};
		htrans <= 2'b10;
		step;
		hsel <= 0;
		htrans <= 2'b00;
		hwdata <= d;
		step;
		v = hrdata;
	endtask
	task rchk(input string nm, input logic [11:0] a, input logic [31:0] e);
		xfer(0, a, 0);
		chk(nm, v, e);
	endtask
	task bump(input int n);
		repeat (n) begin
			glitch <= 1;
			@(posedge hclk);
			glitch <= 0;
			repeat (3) @(posedge hclk);
		end
	endtask
	task tick(input int n);
		repeat (n) @(posedge hclk);
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		tick(16);
		hresetn <= 1;
		tick(1);
		rchk("pmsc", 12'h404, PMSC_RESET);
		rchk("info", 12'h408, LINK_INFO_RESET);
		xfer(1, 12'h500, '1);
		rchk("unmapped", 12'h500, 0);
		link_up <= 1;
		bump(3);
		rchk("lanes", 12'h408, 32'h0053_0003);
		simplex_sublink <= 1;
		rchk("simplex", 12'h408, 32'h0000_0003);
		simplex_sublink <= 0;
		xfer(1, 12'h408, '1);
		rchk("info_wr", 12'h408, 32'h0053_0003);
		xfer(1, 12'h408, 0);
		rchk("cnt_clr", 12'h408, 32'h0053_0000);
		bump(2);
		port_reset_flag <= 1;
		tick(1);
		port_reset_flag <= 0;
		tick(2);
		rchk("pr_clr", 12'h408, 32'h0053_0000);
		link_up <= 0;
		rchk("disc", 12'h408, 0);
		xfer(1, 12'h404, 32'h1000_0000);
		rchk("tm_u0", 12'h404, 32'hf000_0000);
		link_up <= 1;
		bump(1);
		xfer(1, 12'h40c, 1);
		rchk("usb2_info", 12'h408, 0);
		go_off <= 1;
		for (int m = 1; m < 16; m++) begin
			xfer(1, 12'h404, {m[3:0], 12'h0, 8'h2a, 8'h00});
			rchk("tm", 12'h404, {m[3:0], 12'h0, 8'h2a, 8'h00});
			chk("active", test_active, m <= 5);
			chk("lpm", lpm_target_valid, 1);
		end
		usb2_line_state <= 0;
		tick(2);
		chk("l0", effective_link_state, PLS_U0);
		usb2_line_state <= 1;
		tick(2);
		chk("l1", effective_link_state, PLS_U2);
		xfer(1, 12'h404, 32'h1000_0000);
		rchk("tm_l1", 12'h404, 32'hf000_0000);
		controller_reset_command <= 1;
		tick(1);
		controller_reset_command <= 0;
		tick(1);
		rchk("crst", 12'h404, 0);
		report_and_stop;
	end
endmodule
